// ===== pafo_pkg.sv
// Constants and carrier types for the port alternate function override block.
// Assumes a single mclk domain; pin-side inputs are synchronised inside the block.
// Operation
// (RQ1) Pull-up override enable selects override value
// (RQ2) Input enable override selects override value
// (RQ3) Reference select forces A3 pull-up, driver off
// (RQ4) A3 input kept when group1 on, not reference
// (RQ5) A7/A6 input kept when group1 on, comparator off
// (RQ6) Software sets ADC pins input, no pull-up
// (RQ7) Group1 interrupt needs global, enable, no mask
// (RQ8) Sleep keeps input buffer for enabled change pins
// (RQ9) Pin changes seen even on outputs
// (RQ10) Unprogrammed fuse makes B7 reset input
// (RQ11) Reset use masks B7 change detection
// (RQ12) B6 is external interrupt 0 when enabled
// (RQ13) B6 is timer0 clock when both selects set
// (RQ14) Interrupt0 or timer0 clock masks B6 changes
// (RQ15) B5 oscillator pin except RC, external, PLL
// (RQ16) B4 oscillator input except RC, PLL
// (RQ17) Oscillator use masks B5/B4 changes
// (RQ18) B3 outputs compare B when direction output
// (RQ19) Compare B output masks B3 changes
// (RQ20) Three-wire: direction bit sets clock direction
// (RQ21) Two-wire: clock pulled low, pull-up off
// (RQ22) B2 inverted PWM B when serial off
package pafo_pkg;

  // ----------------------------------------
  // Field positions, synchroniser stage count and reset values
  // ----------------------------------------
  localparam int PAFO_A_REF_BIT   = 3;
  localparam int PAFO_B_CLK_BIT   = 2;
  localparam int PAFO_B_CMP_BIT   = 3;
  localparam int PAFO_B_OSCI_BIT  = 4;
  localparam int PAFO_B_OSCO_BIT  = 5;
  localparam int PAFO_B_IRQ_BIT   = 6;
  localparam int PAFO_B_RST_BIT   = 7;
  localparam int PAFO_SYNC_STAGES = 3;
  localparam logic [7:0] PAFO_PIN_RESET = 8'h00;

  // Clock source selection reduced from fuses
  typedef enum logic [1:0] {
    PAFO_CLK_RC,
    PAFO_CLK_EXT,
    PAFO_CLK_PLL,
    PAFO_CLK_XTAL
  } pafo_clk_src_type;

  // Serial unit wire mode
  typedef enum logic [1:0] {
    PAFO_USI_OFF,
    PAFO_USI_THREE,
    PAFO_USI_TWO
  } pafo_usi_mode_type;

  // Override set for one pin
  typedef struct packed {
    logic pullup_override_enable;
    logic pullup_override_value;
    logic direction_override_enable;
    logic direction_override_value;
    logic value_override_enable;
    logic value_override_value;
    logic input_enable_override_enable;
    logic input_enable_override_value;
  } pafo_ovr_type;

  // Final control of one pad
  typedef struct packed {
    logic pullup_on;
    logic drive_on;
    logic drive_value;
    logic input_on;
  } pafo_pad_type;

endpackage

// ===== pafo_pin_ctrl.sv
// Generic pin control: merges register bits with one override set.
// Assumes all inputs are on mclk; purely combinational.
`timescale 1ns/1ns
module pafo_pin_ctrl (
  input  wire logic                  dir_bit,
  input  wire logic                  port_bit,
  input  wire logic                  pull_disable,
  input  wire logic                  sleep_active,
  input  wire pafo_pkg::pafo_ovr_type ovr,
  output pafo_pkg::pafo_pad_type     pad
);

  // ----------------------------------------
  // Default paths and override selection
  // ----------------------------------------
  wire logic pull_norm;
  wire logic drv_norm;
  assign pull_norm = ~dir_bit & port_bit & ~pull_disable;
  assign drv_norm  = dir_bit;

  // Overrides win over register state
  assign pad.pullup_on   = ovr.pullup_override_enable ? ovr.pullup_override_value : pull_norm;  // RQ1
  assign pad.drive_on    = ovr.direction_override_enable ? ovr.direction_override_value : drv_norm;
  assign pad.drive_value = ovr.value_override_enable ? ovr.value_override_value : port_bit;
  assign pad.input_on    = ovr.input_enable_override_enable ?
                           ovr.input_enable_override_value : ~sleep_active;  // RQ2

endmodule

// ===== pafo_port_override.sv
// Alternate function override for port A bits 7, 6 and 3 and port B bits 7..2.
// Assumes register bits and peripheral signals are on mclk; pad inputs are async.
`timescale 1ns/1ns
module pafo_port_override (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  // Port registers
  input  wire logic [7:0]                 porta_dir,
  input  wire logic [7:0]                 porta_out,
  input  wire logic [7:0]                 portb_dir,
  input  wire logic [7:0]                 portb_out,
  input  wire logic                       pull_disable,
  input  wire logic                       sleep_active,
  // Peripheral controls
  input  wire logic                       global_irq_flag,
  input  wire logic                       pin_change_group1_enable_bit,
  input  wire logic                       pin_change_group0_enable_bit,
  input  wire logic                       reference_select_bit0,
  input  wire logic                       comparator_disable_bit,
  input  wire logic                       reset_pin_disable_fuse,
  input  wire logic                       external_irq0_enable,
  input  wire logic                       timer0_clk_sel_bit2,
  input  wire logic                       timer0_clk_sel_bit1,
  input  wire pafo_pkg::pafo_clk_src_type clk_source,
  input  wire logic                       timer1_compare_b_enable,
  input  wire logic                       timer1_compare_b_out,
  input  wire logic                       timer1_pwm_b_enable,
  input  wire pafo_pkg::pafo_usi_mode_type usi_mode,
  input  wire logic                       usi_start_detected,
  input  wire logic                       prog_spi_enable,
  // Pads
  input  wire logic [7:0]                 porta_pad_in,
  input  wire logic [7:0]                 portb_pad_in,
  output logic [7:0]                      porta_pad_out,
  output logic [7:0]                      porta_pad_oe,
  output logic [7:0]                      porta_pullup,
  output logic [7:0]                      portb_pad_out,
  output logic [7:0]                      portb_pad_oe,
  output logic [7:0]                      portb_pullup,
  // To peripherals
  output logic [7:0]                      porta_pin_value,
  output logic [7:0]                      portb_pin_value,
  output logic                            external_reset_n,
  output logic                            external_irq0_level,
  output logic                            timer0_count_input,
  output logic                            usi_clk_in,
  output logic                            pin_change_group1,
  output logic                            pin_change_group0
);

  // ----------------------------------------
  // Function selects
  // ----------------------------------------
  wire logic a_ref_used;
  wire logic b7_reset;
  wire logic b6_irq;
  wire logic b6_tclk;
  wire logic b5_io;
  wire logic b4_io;
  wire logic b2_two;
  wire logic b2_three;
  wire logic b2_pwm;
  wire logic g1_en;
  wire logic g0_en;

  assign a_ref_used = reference_select_bit0;
  assign b7_reset   = reset_pin_disable_fuse;  // RQ10
  assign b6_irq     = global_irq_flag & external_irq0_enable;  // RQ12
  assign b6_tclk    = timer0_clk_sel_bit2 & timer0_clk_sel_bit1;  // RQ13
  // Crystal drive on B5 unless RC, external clock or PLL
  assign b5_io      = (clk_source == pafo_pkg::PAFO_CLK_RC) | (clk_source == pafo_pkg::PAFO_CLK_EXT) |
                      (clk_source == pafo_pkg::PAFO_CLK_PLL);  // RQ15
  assign b4_io      = (clk_source == pafo_pkg::PAFO_CLK_RC) | (clk_source == pafo_pkg::PAFO_CLK_PLL);  // RQ16
  assign b2_two     = usi_mode == pafo_pkg::PAFO_USI_TWO;
  assign b2_three   = usi_mode == pafo_pkg::PAFO_USI_THREE;
  assign b2_pwm     = timer1_pwm_b_enable & (usi_mode == pafo_pkg::PAFO_USI_OFF) & ~prog_spi_enable;
  assign g1_en      = global_irq_flag & pin_change_group1_enable_bit;  // RQ7
  assign g0_en      = global_irq_flag & pin_change_group0_enable_bit;

  // ----------------------------------------
  // Per-pin masks (pin not masked = 1)
  // ----------------------------------------
  wire logic [7:0] a_unmask;
  wire logic [7:0] b_unmask;
  assign a_unmask = {comparator_disable_bit, comparator_disable_bit, 2'b00,
                     ~a_ref_used, 3'b000};  // RQ5 RQ4
  assign b_unmask = {~b7_reset,  // RQ11
                     ~(b6_irq | b6_tclk),  // RQ14
                     b5_io, b4_io,  // RQ17
                     ~timer1_compare_b_enable,  // RQ19
                     ~(b2_two | b2_three | b2_pwm), 2'b00};

  // ----------------------------------------
  // Override sets
  // ----------------------------------------
  pafo_pkg::pafo_ovr_type a_ovr [8];
  pafo_pkg::pafo_ovr_type b_ovr [8];
  wire logic b2_drive_low;

  // Open-collector clock pulls low on port zero or start
  assign b2_drive_low = (usi_start_detected | ~portb_out[2]) & portb_dir[2];  // RQ21

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      a_ovr[i] = '0;
      b_ovr[i] = '0;
    end
    // Port A inputs kept alive in sleep for change sensing
    a_ovr[7].input_enable_override_enable = g1_en & a_unmask[7];  // RQ5 RQ8
    a_ovr[7].input_enable_override_value  = 1'b1;
    a_ovr[6].input_enable_override_enable = g1_en & a_unmask[6];  // RQ5 RQ8
    a_ovr[6].input_enable_override_value  = 1'b1;
    a_ovr[3].pullup_override_enable       = a_ref_used;  // RQ3
    a_ovr[3].direction_override_enable    = a_ref_used;  // RQ3
    a_ovr[3].input_enable_override_enable = g1_en & a_unmask[3];  // RQ4 RQ8
    a_ovr[3].input_enable_override_value  = 1'b1;
    // B7 reset: pull-up on, driver and input off
    b_ovr[7].pullup_override_enable       = b7_reset;  // RQ10
    b_ovr[7].pullup_override_value        = 1'b1;
    b_ovr[7].direction_override_enable    = b7_reset;
    b_ovr[7].input_enable_override_enable = g1_en | b7_reset;
    b_ovr[7].input_enable_override_value  = g1_en & ~b7_reset;  // RQ8
    // B6 input forced on for interrupt or change sensing
    b_ovr[6].input_enable_override_enable = (~b6_tclk & g1_en) | b6_irq;
    b_ovr[6].input_enable_override_value  = 1'b1;
    // Oscillator pins leave I/O entirely
    b_ovr[5].pullup_override_enable       = ~b5_io;  // RQ15
    b_ovr[5].direction_override_enable    = ~b5_io;
    b_ovr[5].input_enable_override_enable = g1_en | ~b5_io;
    b_ovr[5].input_enable_override_value  = g1_en & b5_io;
    b_ovr[4].pullup_override_enable       = ~b4_io;  // RQ16
    b_ovr[4].direction_override_enable    = ~b4_io;
    b_ovr[4].input_enable_override_enable = g1_en | ~b4_io;
    b_ovr[4].input_enable_override_value  = g1_en & b4_io;
    // Compare B reaches the pad only through the direction bit
    b_ovr[3].value_override_enable        = timer1_compare_b_enable;  // RQ18
    b_ovr[3].value_override_value         = timer1_compare_b_out;
    b_ovr[3].input_enable_override_enable = g0_en & b_unmask[3];  // RQ8
    b_ovr[3].input_enable_override_value  = 1'b1;
    // B2: two-wire clock, three-wire clock or inverted PWM
    b_ovr[2].pullup_override_enable       = b2_two;  // RQ21
    b_ovr[2].direction_override_enable    = b2_two | prog_spi_enable;  // RQ20
    b_ovr[2].direction_override_value     = b2_two & b2_drive_low & ~prog_spi_enable;
    b_ovr[2].value_override_enable        = (b2_two & portb_dir[2]) | b2_pwm;
    b_ovr[2].value_override_value         = ~(b2_two & portb_dir[2]) & ~timer1_compare_b_out;  // RQ22
    b_ovr[2].input_enable_override_enable = (g0_en & b_unmask[2]) | usi_start_detected;
    b_ovr[2].input_enable_override_value  = 1'b1;
  end

  // ----------------------------------------
  // Pad control per pin
  // ----------------------------------------
  pafo_pkg::pafo_pad_type a_pad [8];
  pafo_pkg::pafo_pad_type b_pad [8];
  logic [7:0] a_in_on;
  logic [7:0] b_in_on;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_pin
      pafo_pin_ctrl u_a (
        .dir_bit      (porta_dir[g]),
        .port_bit     (porta_out[g]),
        .pull_disable (pull_disable),
        .sleep_active (sleep_active),
        .ovr          (a_ovr[g]),
        .pad          (a_pad[g])
      );
      pafo_pin_ctrl u_b (
        .dir_bit      (portb_dir[g]),
        .port_bit     (portb_out[g]),
        .pull_disable (pull_disable),
        .sleep_active (sleep_active),
        .ovr          (b_ovr[g]),
        .pad          (b_pad[g])
      );
      // Two-wire clock is open collector: drive low only
      assign porta_pad_out[g] = a_pad[g].drive_value;
      assign porta_pad_oe[g]  = a_pad[g].drive_on;
      assign porta_pullup[g]  = a_pad[g].pullup_on;
      assign portb_pad_out[g] = (g == 2 && b2_two) ? 1'b0 : b_pad[g].drive_value;
      assign portb_pad_oe[g]  = b_pad[g].drive_on;
      assign portb_pullup[g]  = b_pad[g].pullup_on;
      assign a_in_on[g]       = a_pad[g].input_on;
      assign b_in_on[g]       = b_pad[g].input_on;
    end
  endgenerate

  // ----------------------------------------
  // Input synchronisers, three stages
  // ----------------------------------------
  logic [7:0] a_s1_reg;
  logic [7:0] a_s2_reg;
  logic [7:0] a_s3_reg;
  logic [7:0] b_s1_reg;
  logic [7:0] b_s2_reg;
  logic [7:0] b_s3_reg;
  logic [7:0] a_val_reg;
  logic [7:0] b_val_reg;
  logic [7:0] a_val_next;
  logic [7:0] b_val_next;

  // Disabled buffers read low, as a clamped input would
  assign a_val_next = (a_s2_reg == a_s3_reg) ? (a_s2_reg & a_in_on) : (a_val_reg & a_in_on);
  assign b_val_next = (b_s2_reg == b_s3_reg) ? (b_s2_reg & b_in_on) : (b_val_reg & b_in_on);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_s1_reg  <= pafo_pkg::PAFO_PIN_RESET;
      a_s2_reg  <= pafo_pkg::PAFO_PIN_RESET;
      a_s3_reg  <= pafo_pkg::PAFO_PIN_RESET;
      b_s1_reg  <= pafo_pkg::PAFO_PIN_RESET;
      b_s2_reg  <= pafo_pkg::PAFO_PIN_RESET;
      b_s3_reg  <= pafo_pkg::PAFO_PIN_RESET;
      a_val_reg <= pafo_pkg::PAFO_PIN_RESET;
      b_val_reg <= pafo_pkg::PAFO_PIN_RESET;
    end else begin
      a_s1_reg  <= porta_pad_in;
      a_s2_reg  <= a_s1_reg;
      a_s3_reg  <= a_s2_reg;
      b_s1_reg  <= portb_pad_in;
      b_s2_reg  <= b_s1_reg;
      b_s3_reg  <= b_s2_reg;
      a_val_reg <= a_val_next;
      b_val_reg <= b_val_next;
    end
  end

  // ----------------------------------------
  // Pin change detection
  // ----------------------------------------
  // Compares resolved value with its previous, so driven outputs count too
  logic [7:0] a_prev_reg;
  logic [7:0] b_prev_reg;
  logic       g1_reg;
  logic       g0_reg;
  wire logic  g1_next;
  wire logic  g0_next;
  wire logic [7:0] a_chg;
  wire logic [7:0] b_chg;

  assign a_chg   = (a_val_reg ^ a_prev_reg) & a_unmask;  // RQ9
  assign b_chg   = (b_val_reg ^ b_prev_reg) & b_unmask;  // RQ9
  assign g1_next = g1_en & ((|a_chg) | (|b_chg[7:4]));  // RQ7
  assign g0_next = g0_en & (|b_chg[3:2]);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      a_prev_reg <= pafo_pkg::PAFO_PIN_RESET;
      b_prev_reg <= pafo_pkg::PAFO_PIN_RESET;
      g1_reg     <= 1'b0;
      g0_reg     <= 1'b0;
    end else begin
      a_prev_reg <= a_val_reg;
      b_prev_reg <= b_val_reg;
      g1_reg     <= g1_next;
      g0_reg     <= g0_next;
    end
  end

  // ----------------------------------------
  // Outputs to peripherals
  // ----------------------------------------
  // Reset reads the synchronised pad, not the gated value, since its buffer is off
  assign porta_pin_value     = a_val_reg;
  assign portb_pin_value     = b_val_reg;
  assign external_reset_n    = b7_reset ? b_s3_reg[pafo_pkg::PAFO_B_RST_BIT] : 1'b1;
  assign external_irq0_level = b_val_reg[pafo_pkg::PAFO_B_IRQ_BIT];
  assign timer0_count_input  = b6_tclk & b_val_reg[pafo_pkg::PAFO_B_IRQ_BIT];
  assign usi_clk_in          = b_val_reg[pafo_pkg::PAFO_B_CLK_BIT];
  assign pin_change_group1   = g1_reg;
  assign pin_change_group0   = g0_reg;

endmodule

// ===== pafo_pad_model.sv
// Board-side pad model for one eight-bit port of the override block.
// Assumes weak board pull-downs on every pad and a bench that drives pads.
`timescale 1ns/1ns
module pafo_pad_model (
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pull_en,
  input  wire logic [7:0] drv_val,
  input  wire logic [7:0] drv_en,
  output logic      [7:0] pad_in
);
  // ----------------------------------------
  // Pad resolution
  // ----------------------------------------
  // Block drive wins, then bench drive, then pull-up, then board pull-down;
  // a released pad never keeps its last value.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) begin
        pad_in[i] = pad_out[i];
      end else if (drv_en[i]) begin
        pad_in[i] = drv_val[i];
      end else begin
        pad_in[i] = pull_en[i];
      end
    end
  end
endmodule

// ===== pafo_port_override_properties.sv
// Concurrent checks on the pin override block, seen from its ports only.
// Assumes one mclk domain and rst_n as asynchronous active-low reset.
`timescale 1ns/1ns
module pafo_port_override_properties (
  input wire logic                        mclk,
  input wire logic                        rst_n,
  input wire logic [7:0]                  portb_dir,
  input wire logic [7:0]                  portb_out,
  input wire logic                        global_irq_flag,
  input wire logic                        reference_select_bit0,
  input wire logic                        reset_pin_disable_fuse,
  input wire pafo_pkg::pafo_clk_src_type  clk_source,
  input wire logic                        timer1_compare_b_enable,
  input wire logic                        timer1_compare_b_out,
  input wire logic                        timer1_pwm_b_enable,
  input wire pafo_pkg::pafo_usi_mode_type usi_mode,
  input wire logic                        prog_spi_enable,
  input wire logic [7:0]                  portb_pad_in,
  input wire logic [7:0]                  porta_pad_oe,
  input wire logic [7:0]                  porta_pullup,
  input wire logic [7:0]                  portb_pad_out,
  input wire logic [7:0]                  portb_pad_oe,
  input wire logic [7:0]                  portb_pullup,
  input wire logic [7:0]                  portb_pin_value,
  input wire logic                        external_reset_n,
  input wire logic                        pin_change_group1
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Held conditions; lengths cover the three synchroniser stages
  sequence s_gie_off;  !global_irq_flag [*3]; endsequence
  sequence s_fuse_on;  reset_pin_disable_fuse [*5]; endsequence
  sequence s_rst_low;  (reset_pin_disable_fuse && !portb_pad_in[7]) [*4]; endsequence

  ref_pin_off_a: assert property (
    reference_select_bit0 |-> !porta_pullup[3] && !porta_pad_oe[3])
    else $error("A3 pull-up or driver on while reference");
  reset_pin_pads_a: assert property (
    reset_pin_disable_fuse |-> portb_pullup[7] && !portb_pad_oe[7])
    else $error("B7 reset pin pads wrong");
  reset_input_off_a: assert property (
    s_fuse_on |-> portb_pin_value[7] == 1'b0)
    else $error("B7 input seen while reset pin");
  reset_sync_a: assert property (
    s_rst_low |-> !external_reset_n)
    else $error("Reset pin low not passed on");
  osc_out_pin_a: assert property (
    clk_source == pafo_pkg::PAFO_CLK_XTAL |-> !portb_pad_oe[5] && !portb_pullup[5])
    else $error("B5 driven while oscillator pin");
  osc_in_pin_a: assert property (
    clk_source inside {pafo_pkg::PAFO_CLK_EXT, pafo_pkg::PAFO_CLK_XTAL} |-> !portb_pad_oe[4])
    else $error("B4 driven while oscillator input");
  compare_b_out_a: assert property (
    timer1_compare_b_enable && portb_dir[3] |-> portb_pad_oe[3] && portb_pad_out[3] == timer1_compare_b_out)
    else $error("B3 compare output wrong");
  spi_clk_in_a: assert property (
    usi_mode == pafo_pkg::PAFO_USI_THREE && prog_spi_enable |-> !portb_pad_oe[2])
    else $error("B2 driven while programming SPI");
  scl_hold_low_a: assert property (
    usi_mode == pafo_pkg::PAFO_USI_TWO && portb_dir[2] && !portb_out[2] && !prog_spi_enable
      |-> portb_pad_oe[2] && !portb_pad_out[2] && !portb_pullup[2])
    else $error("B2 clock not pulled low");
  pwm_inverted_a: assert property (
    usi_mode == pafo_pkg::PAFO_USI_OFF && !prog_spi_enable && timer1_pwm_b_enable && portb_dir[2]
      |-> portb_pad_oe[2] && portb_pad_out[2] == !timer1_compare_b_out)
    else $error("B2 inverted PWM wrong");
  irq_gate_a: assert property (
    s_gie_off |=> !pin_change_group1)
    else $error("Pin change pulse with interrupts off");
endmodule

// ===== tb_pafo_port_override.sv
// Self-checking bench for the pin override block with pad models on both ports.
// Assumes a 50 MHz mclk; inputs change on the falling edge.
`timescale 1ns/1ns
module tb_pafo_port_override;
  `define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin bad_count++; \
    $display("[FAIL] %0t got %0b exp %0b", $time, got, exp); end end
  logic                        mclk, rst_n, pull_disable, sleep_active, global_irq_flag;
  logic                        pin_change_group1_enable_bit, pin_change_group0_enable_bit;
  logic                        reference_select_bit0, comparator_disable_bit, reset_pin_disable_fuse;
  logic                        external_irq0_enable, timer0_clk_sel_bit2, timer0_clk_sel_bit1;
  logic                        timer1_compare_b_enable, timer1_compare_b_out, timer1_pwm_b_enable;
  logic                        usi_start_detected, prog_spi_enable, external_reset_n, external_irq0_level;
  logic                        timer0_count_input, usi_clk_in, pin_change_group1, pin_change_group0;
  logic [7:0]                  porta_dir, porta_out, portb_dir, portb_out, porta_pad_in, portb_pad_in;
  logic [7:0]                  porta_pad_out, porta_pad_oe, porta_pullup, portb_pad_out, portb_pad_oe;
  logic [7:0]                  portb_pullup, porta_pin_value, portb_pin_value, drv_a, drv_b;
  pafo_pkg::pafo_clk_src_type  clk_source;
  pafo_pkg::pafo_usi_mode_type usi_mode;
  int                          bad_count = 0;
  int                          cmp_count = 0;
  int                          pa[3] = '{7, 6, 3};

  pafo_port_override i_dut (.mclk, .rst_n, .porta_dir, .porta_out, .portb_dir, .portb_out,
    .pull_disable, .sleep_active, .global_irq_flag, .pin_change_group1_enable_bit,
    .pin_change_group0_enable_bit, .reference_select_bit0, .comparator_disable_bit,
    .reset_pin_disable_fuse, .external_irq0_enable, .timer0_clk_sel_bit2, .timer0_clk_sel_bit1,
    .clk_source, .timer1_compare_b_enable, .timer1_compare_b_out, .timer1_pwm_b_enable, .usi_mode,
    .usi_start_detected, .prog_spi_enable, .porta_pad_in, .portb_pad_in, .porta_pad_out,
    .porta_pad_oe, .porta_pullup, .portb_pad_out, .portb_pad_oe, .portb_pullup, .porta_pin_value,
    .portb_pin_value, .external_reset_n, .external_irq0_level, .timer0_count_input, .usi_clk_in,
    .pin_change_group1, .pin_change_group0);
  pafo_pad_model i_pad_a (.pad_out(porta_pad_out), .pad_oe(porta_pad_oe), .pull_en(porta_pullup),
    .drv_val(drv_a), .drv_en(8'hFF), .pad_in(porta_pad_in));
  pafo_pad_model i_pad_b (.pad_out(portb_pad_out), .pad_oe(portb_pad_oe), .pull_en(portb_pullup),
    .drv_val(drv_b), .drv_en(8'hFF), .pad_in(portb_pad_in));

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wt(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic defaults;
    {porta_dir, porta_out, portb_dir, portb_out, drv_a, drv_b} = '0;
    {pull_disable, sleep_active, reference_select_bit0, reset_pin_disable_fuse} = '0;
    {external_irq0_enable, timer0_clk_sel_bit2, timer0_clk_sel_bit1, usi_start_detected} = '0;
    {timer1_compare_b_enable, timer1_compare_b_out, timer1_pwm_b_enable, prog_spi_enable} = '0;
    {global_irq_flag, pin_change_group1_enable_bit, pin_change_group0_enable_bit} = '1;
    comparator_disable_bit = 1'b1;
    clk_source = pafo_pkg::PAFO_CLK_RC;
    usi_mode = pafo_pkg::PAFO_USI_OFF;
  endtask
  // Settle first so config changes cannot leak pulses into the window
  task automatic pc(input bit pb, input int idx, input bit g1, input int exp);
    int seen;
    seen = 0;
    wt(8);
    if (pb) begin
      drv_b[idx] = ~drv_b[idx];
      portb_out[idx] = ~portb_out[idx];
    end else begin
      drv_a[idx] = ~drv_a[idx];
      porta_out[idx] = ~porta_out[idx];
    end
    repeat (8) begin
      @(negedge mclk);
      if ((g1 ? pin_change_group1 : pin_change_group0) === 1'b1) seen++;
    end
    `CHK(seen, exp)
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_a3;
    porta_dir = 8'h08;
    porta_out = 8'h08;
    reference_select_bit0 = 1'b1;
    wt(1);
    `CHK(porta_pad_oe[3], 1'b0)
    porta_dir = 8'h00;
    wt(1);
    `CHK(porta_pullup[3], 1'b0)
    reference_select_bit0 = 1'b0;
    wt(1);
    `CHK(porta_pullup[3], 1'b1)
  endtask
  task automatic t_b_static;
    reset_pin_disable_fuse = 1'b1;
    portb_dir = 8'hFF;
    pull_disable = 1'b1;
    wt(1);
    `CHK(portb_pullup[7], 1'b1)
    `CHK(portb_pad_oe[7], 1'b0)
    for (int s = 0; s < 4; s++) begin
      clk_source = pafo_pkg::pafo_clk_src_type'(s[1:0]);
      wt(1);
      `CHK(portb_pad_oe[5], s != 3)
      `CHK(portb_pad_oe[4], s == 0 || s == 2)
    end
    {timer1_compare_b_enable, timer1_compare_b_out, timer1_pwm_b_enable} = 3'h7;
    wt(1);
    `CHK(portb_pad_out[3], 1'b1)
    `CHK(portb_pad_out[2], 1'b0)
    portb_dir = 8'h00;
    wt(1);
    `CHK(portb_pad_oe[3], 1'b0)
    `CHK(portb_pad_oe[2], 1'b0)
    portb_dir = 8'h04;
    usi_mode = pafo_pkg::PAFO_USI_THREE;
    timer1_pwm_b_enable = 1'b0;
    wt(1);
    `CHK(portb_pad_oe[2], 1'b1)
    prog_spi_enable = 1'b1;
    wt(1);
    `CHK(portb_pad_oe[2], 1'b0)
    prog_spi_enable = 1'b0;
    usi_mode = pafo_pkg::PAFO_USI_TWO;
    portb_out = 8'h04;
    wt(1);
    `CHK(portb_pad_oe[2], 1'b0)
    usi_start_detected = 1'b1;
    wt(1);
    `CHK(portb_pad_oe[2], 1'b1)
    `CHK(portb_pad_out[2], 1'b0)
    {usi_start_detected, portb_out} = '0;
    wt(1);
    `CHK(portb_pad_oe[2], 1'b1)
    {portb_dir, pull_disable, portb_out} = {8'h00, 1'b0, 8'h04};
    wt(1);
    `CHK(portb_pullup[2], 1'b0)
  endtask
  task automatic t_change;
    sleep_active = 1'b1;
    foreach (pa[i]) pc(1'b0, pa[i], 1'b1, 1);
    for (int i = 2; i < 8; i++) pc(1'b1, i, i > 3, 1);
    sleep_active = 1'b0;
    portb_dir = 8'h08;
    pc(1'b1, 3, 1'b0, 1);
    portb_dir = 8'h00;
    comparator_disable_bit = 1'b0;
    pc(1'b0, 7, 1'b1, 0);
    {comparator_disable_bit, reference_select_bit0} = 2'h3;
    pc(1'b0, 3, 1'b1, 0);
    {reference_select_bit0, reset_pin_disable_fuse} = 2'h1;
    pc(1'b1, 7, 1'b1, 0);
    drv_b[7] = 1'b0;
    wt(6);
    `CHK(external_reset_n, 1'b0)
    {reset_pin_disable_fuse, external_irq0_enable} = 2'h1;
    pc(1'b1, 6, 1'b1, 0);
    `CHK(external_irq0_level, drv_b[6])
    {external_irq0_enable, timer0_clk_sel_bit2, timer0_clk_sel_bit1} = 3'h3;
    pc(1'b1, 6, 1'b1, 0);
    `CHK(timer0_count_input, drv_b[6])
    `CHK(usi_clk_in, drv_b[2])
    `CHK(porta_pin_value[6], drv_a[6])
    {timer0_clk_sel_bit2, timer0_clk_sel_bit1} = 2'h0;
    clk_source = pafo_pkg::PAFO_CLK_XTAL;
    pc(1'b1, 5, 1'b1, 0);
    pc(1'b1, 4, 1'b1, 0);
    clk_source = pafo_pkg::PAFO_CLK_RC;
    timer1_compare_b_enable = 1'b1;
    pc(1'b1, 3, 1'b0, 0);
    {timer1_compare_b_enable, global_irq_flag} = 2'h0;
    pc(1'b0, 6, 1'b1, 0);
    {global_irq_flag, pin_change_group1_enable_bit} = 2'h2;
    pc(1'b0, 6, 1'b1, 0);
  endtask

  task automatic close_out;
    $display("TB: %0d mismatches in %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Scenarios need about 350 cycles; the 5000-cycle limit, about fourteen times that, marks a hang
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
  initial begin
    defaults();
    rst_n = 1'b0;
    wt(4);
    rst_n = 1'b1;
    t_a3();
    defaults();
    t_b_static();
    defaults();
    t_change();
    close_out();
  end
endmodule

bind pafo_port_override pafo_port_override_properties i_props (.mclk, .rst_n, .portb_dir, .portb_out,
  .global_irq_flag, .reference_select_bit0, .reset_pin_disable_fuse, .clk_source, .timer1_compare_b_enable,
  .timer1_compare_b_out, .timer1_pwm_b_enable, .usi_mode, .prog_spi_enable, .portb_pad_in, .porta_pad_oe,
  .porta_pullup, .portb_pad_out, .portb_pad_oe, .portb_pullup, .portb_pin_value, .external_reset_n,
  .pin_change_group1);
